// ==== common/gpic_pkg.sv ====
// Purpose: Shared constants of the interrupt controller.
// Assumes: Register indices are byte addresses divided by four.
// Notes:   Sources are numbered in natural order, first source is index 0.
package gpic_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_SRC   = 8;
    localparam int NUM_GRP   = 6;
    localparam int STACK_MAX = 4;
    localparam int ADDR_W    = 10;

    // ----------------------------------------------------------------
    // Register indices and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_ENABLE_PRIMARY   = 8'hA8;
    localparam logic [7:0] IDX_PRIO_LOW         = 8'hA9;
    localparam logic [7:0] IDX_PRIO_HIGH        = 8'hB9;
    localparam logic [7:0] IDX_ENABLE_SECONDARY = 8'h9A;
    localparam logic [7:0] IDX_FLAGS_SECONDARY  = 8'hBF;
    localparam logic [7:0] IDX_TIMER_CTRL       = 8'h88;
    localparam logic [7:0] IDX_SERIAL_CTRL      = 8'h98;
    localparam logic [7:0] REG_RESET            = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PRIO_W         = 6;
    localparam int POS_GLOBAL_EN  = 7;
    localparam int POS_SERIAL_EN  = 4;
    localparam int POS_T1_EN      = 3;
    localparam int POS_EXT_B_EN   = 2;
    localparam int POS_T0_EN      = 1;
    localparam int POS_EXT_A_EN   = 0;
    localparam int POS_EXT_C      = 2;
    localparam int POS_T3         = 1;
    localparam int POS_ADC        = 0;
    localparam int POS_T1_FLAG    = 7;
    localparam int POS_T0_FLAG    = 5;
    localparam int POS_EXT_B_FLAG = 3;
    localparam int POS_EXT_A_FLAG = 1;
    localparam int POS_TX_FLAG    = 1;
    localparam int POS_RX_FLAG    = 0;

    // ----------------------------------------------------------------
    // Sources in natural order, groups and vectors
    // ----------------------------------------------------------------
    localparam int SRC_EXT_A = 0;
    localparam int SRC_EXT_C = 1;
    localparam int SRC_T0    = 2;
    localparam int SRC_ADC   = 3;
    localparam int SRC_EXT_B = 4;
    localparam int SRC_T1    = 5;
    localparam int SRC_UART  = 6;
    localparam int SRC_T3    = 7;
    localparam logic [23:0] SRC_GROUP = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
    localparam logic [127:0] SRC_VECTOR = {16'h00EB, 16'h0023, 16'h001B, 16'h0013,
                                           16'h008B, 16'h000B, 16'h0083, 16'h0003};

    typedef enum logic [0:0] {
        GPIC_AP_WAIT = 1'b0,
        GPIC_AP_DONE = 1'b1
    } gpic_apb_state_t;

endpackage

// ==== design/gpic_arbiter.sv ====
// Purpose: Picks the winner by level, then natural order.
// Assumes: Pending inputs are already gated by flag and enables.
// Notes:   Purely combinational.
module gpic_arbiter #(
    parameter int NUM_SRC = gpic_pkg::NUM_SRC,
    parameter int NUM_GRP = gpic_pkg::NUM_GRP
) (
    // Requests and levels
    input  wire logic [NUM_SRC-1:0] pending,
    input  wire logic [NUM_GRP-1:0] prio_low,
    input  wire logic [NUM_GRP-1:0] prio_high,
    // Winner
    output logic                    win_valid,
    output logic [2:0]              win_src,
    output logic [1:0]              win_level
);

    if (NUM_SRC != 8 || NUM_GRP != 6) begin : g_bad_size
        $error("gpic_arbiter serves eight sources in six groups only");
    end

    logic [NUM_GRP-1:0] grp_active;
    logic [1:0]         grp_level [NUM_GRP];
    logic [1:0]         max_level;
    logic [2:0]         win_grp;
    logic               grp_found;

    // ----------------------------------------------------------------
    // Per group level and activity
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        assign grp_level[g] = {prio_high[g], prio_low[g]}; // RQ4 RQ6
        always_comb begin
            grp_active[g] = 1'b0;
            for (int s = 0; s < NUM_SRC; s++) begin
                if (gpic_pkg::SRC_GROUP[s*3 +: 3] == 3'(g) && pending[s]) begin // RQ5
                    grp_active[g] = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Three step selection
    // ----------------------------------------------------------------
    always_comb begin
        max_level = 2'h0;
        for (int g = 0; g < NUM_GRP; g++) begin
            if (grp_active[g] && grp_level[g] > max_level) begin // RQ3 RQ8
                max_level = grp_level[g];
            end
        end
        grp_found = 1'b0;
        win_grp   = 3'h0;
        for (int g = 0; g < NUM_GRP; g++) begin
            if (!grp_found && grp_active[g] && grp_level[g] == max_level) begin // RQ8 RQ1
                grp_found = 1'b1;
                win_grp   = 3'(g);
            end
        end
        win_valid = 1'b0;
        win_src   = 3'h0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (!win_valid && pending[s] && gpic_pkg::SRC_GROUP[s*3 +: 3] == win_grp) begin // RQ8
                win_valid = 1'b1;
                win_src   = 3'(s);
            end
        end
        win_level = max_level;
    end

endmodule

// ==== design/gpic_ctrl.sv ====
// Purpose: Grouped priority interrupt controller with APB registers.
// Assumes: Event inputs are one-cycle pulses from logic on the same clock.
// Notes:   irq_ack takes a request, irq_return ends it.
//
// Summary of operation
// RQ1: Equal level, simultaneous requests: natural order first, other waits.
// RQ2: Same or lower level never interrupts a running routine.
// RQ3: Four levels, 3 highest, natural order only breaks ties.
// RQ4: Group level is high register bit over low register bit.
// RQ5: Eight sources map onto six fixed groups.
// RQ6: All sources of a group share that group's level.
// RQ7: Strictly higher level preempts; lower waits for higher routines.
// RQ8: Winner: highest level, then first group, then first source.
// RQ9: Priority registers hold six r/w bits, reset zero, top bits read zero.
// RQ10: Enabled flags clear on dispatch; disabled flags only by software.
// RQ11: Writing one to a flag bit is ignored; zero clears it.
// RQ12: Software should write ones to flags it must keep.
// RQ13: Global enable in bit 7, reset zero, blocks all dispatch.
// RQ14: Primary enables: UART 4, timer one 3, ext B 2, timer zero 1, ext A 0.
// RQ15: Natural order and vectors fixed per source.
// RQ16: Request needs flag, own enable and global enable; flag sets always.
// RQ17: Secondary enables: ext C 2, timer three 1, converter 0.
// RQ18: Secondary flags: ext C 2, timer three 1, converter 0, reset zero.
// RQ19: Stack of in-service levels, push on dispatch, pop on return.
// RQ20: UART flags are never cleared by dispatch.
//
// Decided for this implementation: register access over APB.
module gpic_ctrl (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // APB slave
    input  wire logic [gpic_pkg::ADDR_W-1:0] paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Source events
    input  wire logic [7:0]                  src_event,
    input  wire logic                        serial_tx_event,
    // CPU core
    output logic                             irq_req,
    output logic [15:0]                      irq_vector,
    output logic [1:0]                       irq_level,
    input  wire logic                        irq_ack,
    input  wire logic                        irq_return
);

    typedef struct packed {
        gpic_pkg::gpic_apb_state_t ap;
        logic [7:0]                rdata;
        logic                      slverr;
        logic                      global_en;
        logic [4:0]                en_pri;
        logic [2:0]                en_sec;
        logic [5:0]                prio_lo;
        logic [5:0]                prio_hi;
        logic [7:0]                flag;
        logic                      tx_flag;
        logic [7:0]                stack;
        logic [2:0]                depth;
        logic                      req;
        logic [2:0]                src;
        logic [1:0]                lvl;
        logic [15:0]               vec;
    } gpic_state_t;

    gpic_state_t s_q;
    gpic_state_t s_d;

    logic [7:0] src_en;
    logic [7:0] flag_any;
    logic [7:0] pending;
    logic       win_valid;
    logic [2:0] win_src;
    logic [1:0] win_level;

    // ----------------------------------------------------------------
    // Per source enable and pending
    // ----------------------------------------------------------------
    assign src_en[gpic_pkg::SRC_EXT_A] = s_q.en_pri[gpic_pkg::POS_EXT_A_EN]; // RQ14
    assign src_en[gpic_pkg::SRC_EXT_C] = s_q.en_sec[gpic_pkg::POS_EXT_C];    // RQ17
    assign src_en[gpic_pkg::SRC_T0]    = s_q.en_pri[gpic_pkg::POS_T0_EN];    // RQ14
    assign src_en[gpic_pkg::SRC_ADC]   = s_q.en_sec[gpic_pkg::POS_ADC];      // RQ17
    assign src_en[gpic_pkg::SRC_EXT_B] = s_q.en_pri[gpic_pkg::POS_EXT_B_EN]; // RQ14
    assign src_en[gpic_pkg::SRC_T1]    = s_q.en_pri[gpic_pkg::POS_T1_EN];    // RQ14
    assign src_en[gpic_pkg::SRC_UART]  = s_q.en_pri[gpic_pkg::POS_SERIAL_EN]; // RQ14
    assign src_en[gpic_pkg::SRC_T3]    = s_q.en_sec[gpic_pkg::POS_T3];       // RQ17

    for (genvar i = 0; i < gpic_pkg::NUM_SRC; i++) begin : g_src
        if (i == gpic_pkg::SRC_UART) begin : g_uart
            assign flag_any[i] = s_q.flag[i] | s_q.tx_flag;
        end else begin : g_plain
            assign flag_any[i] = s_q.flag[i];
        end
        assign pending[i] = flag_any[i] & src_en[i] & s_q.global_en; // RQ16 RQ13
    end

    gpic_arbiter #(
        .NUM_SRC (gpic_pkg::NUM_SRC),
        .NUM_GRP (gpic_pkg::NUM_GRP)
    ) u_arbiter (
        .pending   (pending),
        .prio_low  (s_q.prio_lo),
        .prio_high (s_q.prio_hi),
        .win_valid (win_valid),
        .win_src   (win_src),
        .win_level (win_level)
    );

    // ----------------------------------------------------------------
    // Register read view
    // ----------------------------------------------------------------
    function automatic logic [7:0] read_reg(input gpic_state_t s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            gpic_pkg::IDX_ENABLE_PRIMARY: begin
                v[gpic_pkg::POS_GLOBAL_EN] = s.global_en;
                v[4:0]                     = s.en_pri;
            end
            gpic_pkg::IDX_PRIO_LOW: begin
                v[5:0] = s.prio_lo; // RQ9
            end
            gpic_pkg::IDX_PRIO_HIGH: begin
                v[5:0] = s.prio_hi; // RQ9
            end
            gpic_pkg::IDX_ENABLE_SECONDARY: begin
                v[2:0] = s.en_sec;
            end
            gpic_pkg::IDX_FLAGS_SECONDARY: begin
                v[gpic_pkg::POS_EXT_C] = s.flag[gpic_pkg::SRC_EXT_C]; // RQ18
                v[gpic_pkg::POS_T3]    = s.flag[gpic_pkg::SRC_T3];
                v[gpic_pkg::POS_ADC]   = s.flag[gpic_pkg::SRC_ADC];
            end
            gpic_pkg::IDX_TIMER_CTRL: begin
                v[gpic_pkg::POS_T1_FLAG]    = s.flag[gpic_pkg::SRC_T1];
                v[gpic_pkg::POS_T0_FLAG]    = s.flag[gpic_pkg::SRC_T0];
                v[gpic_pkg::POS_EXT_B_FLAG] = s.flag[gpic_pkg::SRC_EXT_B];
                v[gpic_pkg::POS_EXT_A_FLAG] = s.flag[gpic_pkg::SRC_EXT_A];
            end
            gpic_pkg::IDX_SERIAL_CTRL: begin
                v[gpic_pkg::POS_TX_FLAG] = s.tx_flag;
                v[gpic_pkg::POS_RX_FLAG] = s.flag[gpic_pkg::SRC_UART];
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        return idx == gpic_pkg::IDX_ENABLE_PRIMARY || idx == gpic_pkg::IDX_PRIO_LOW
            || idx == gpic_pkg::IDX_PRIO_HIGH || idx == gpic_pkg::IDX_ENABLE_SECONDARY
            || idx == gpic_pkg::IDX_FLAGS_SECONDARY || idx == gpic_pkg::IDX_TIMER_CTRL
            || idx == gpic_pkg::IDX_SERIAL_CTRL;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] idx;
        logic       word_ok;
        logic       wr_fire;
        logic [7:0] wd;
        logic [7:0] clr;
        logic       clr_tx;
        logic       take;
        logic [2:0] dep;
        logic [1:0] top;
        logic       preempt;
        idx     = paddr[gpic_pkg::ADDR_W-1:2];
        word_ok = (paddr[1:0] == 2'h0) && is_mapped(idx);
        wr_fire = psel && penable && pwrite && s_q.ap == gpic_pkg::GPIC_AP_DONE;
        wd      = pwdata[7:0];
        clr     = 8'h00;
        clr_tx  = 1'b0;
        take    = irq_ack && s_q.req;
        dep     = s_q.depth;
        top     = s_q.stack[{s_q.depth[1:0] - 2'h1, 1'b0} +: 2];
        preempt = (s_q.depth == 3'h0) || (win_level > top); // RQ2 RQ7 RQ19
        s_d     = s_q;

        // Two cycle access: pready rises one cycle into the access phase.
        case (s_q.ap)
            gpic_pkg::GPIC_AP_WAIT: begin
                if (psel && penable) begin
                    s_d.ap     = gpic_pkg::GPIC_AP_DONE;
                    s_d.slverr = !word_ok;
                    s_d.rdata  = (word_ok && !pwrite) ? read_reg(s_q, idx) : 8'h00;
                end
            end
            gpic_pkg::GPIC_AP_DONE: begin
                s_d.ap     = gpic_pkg::GPIC_AP_WAIT;
                s_d.slverr = 1'b0;
                s_d.rdata  = 8'h00;
            end
            default: begin
                s_d.ap = gpic_pkg::GPIC_AP_WAIT;
            end
        endcase

        // Writes land on the completing edge.
        if (wr_fire && word_ok) begin
            case (idx)
                gpic_pkg::IDX_ENABLE_PRIMARY: begin
                    s_d.global_en = wd[gpic_pkg::POS_GLOBAL_EN]; // RQ13
                    s_d.en_pri    = wd[4:0];                     // RQ14
                end
                gpic_pkg::IDX_PRIO_LOW: begin
                    s_d.prio_lo = wd[gpic_pkg::PRIO_W-1:0]; // RQ9
                end
                gpic_pkg::IDX_PRIO_HIGH: begin
                    s_d.prio_hi = wd[gpic_pkg::PRIO_W-1:0]; // RQ9
                end
                gpic_pkg::IDX_ENABLE_SECONDARY: begin
                    s_d.en_sec = wd[2:0]; // RQ17
                end
                gpic_pkg::IDX_FLAGS_SECONDARY: begin
                    clr[gpic_pkg::SRC_EXT_C] = !wd[gpic_pkg::POS_EXT_C]; // RQ11
                    clr[gpic_pkg::SRC_T3]    = !wd[gpic_pkg::POS_T3];
                    clr[gpic_pkg::SRC_ADC]   = !wd[gpic_pkg::POS_ADC];
                end
                gpic_pkg::IDX_TIMER_CTRL: begin
                    clr[gpic_pkg::SRC_T1]    = !wd[gpic_pkg::POS_T1_FLAG]; // RQ11
                    clr[gpic_pkg::SRC_T0]    = !wd[gpic_pkg::POS_T0_FLAG];
                    clr[gpic_pkg::SRC_EXT_B] = !wd[gpic_pkg::POS_EXT_B_FLAG];
                    clr[gpic_pkg::SRC_EXT_A] = !wd[gpic_pkg::POS_EXT_A_FLAG];
                end
                gpic_pkg::IDX_SERIAL_CTRL: begin
                    clr_tx                  = !wd[gpic_pkg::POS_TX_FLAG]; // RQ11 RQ20
                    clr[gpic_pkg::SRC_UART] = !wd[gpic_pkg::POS_RX_FLAG];
                end
                default: begin
                    clr = 8'h00;
                end
            endcase
        end

        // Dispatch clears the granted flag, UART excepted.
        if (take && s_q.src != 3'(gpic_pkg::SRC_UART)) begin // RQ10 RQ20
            clr[s_q.src] = 1'b1;
        end

        // A new event wins over a clear in the same cycle.
        s_d.flag    = (s_q.flag & ~clr) | src_event;           // RQ16 RQ12
        s_d.tx_flag = (s_q.tx_flag & ~clr_tx) | serial_tx_event;

        // Level stack: pop on return, then push.
        if (irq_return && dep != 3'h0) begin // RQ19
            dep = dep - 3'h1;
        end
        if (take && dep < 3'(gpic_pkg::STACK_MAX)) begin // RQ19
            s_d.stack[{dep[1:0], 1'b0} +: 2] = s_q.lvl;
            dep = dep + 3'h1;
        end
        s_d.depth = dep;

        // Preemption compares against the current top entry.
        s_d.req = win_valid && preempt && !take && !irq_return; // RQ1 RQ13
        s_d.src = win_src;
        s_d.lvl = win_level;
        s_d.vec = gpic_pkg::SRC_VECTOR[{win_src, 4'h0} +: 16]; // RQ15
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.ap        <= gpic_pkg::GPIC_AP_WAIT;
            s_q.en_pri    <= gpic_pkg::REG_RESET[4:0];
            s_q.en_sec    <= gpic_pkg::REG_RESET[2:0];
            s_q.prio_lo   <= gpic_pkg::REG_RESET[5:0];
            s_q.prio_hi   <= gpic_pkg::REG_RESET[5:0];
            s_q.flag      <= gpic_pkg::REG_RESET;
            s_q.global_en <= 1'b0;
            s_q.vec       <= gpic_pkg::SRC_VECTOR[15:0];
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata     = {24'h000000, s_q.rdata};
    assign pready     = s_q.ap == gpic_pkg::GPIC_AP_DONE;
    assign pslverr    = s_q.slverr;
    assign irq_req    = s_q.req;
    assign irq_vector = s_q.vec;
    assign irq_level  = s_q.lvl;

endmodule

// ==== test/gpic_cpu_model.sv ====
// Purpose: CPU core that acknowledges and ends interrupts.
// Assumes: irq_req stands until acknowledged.
// Notes:   Slow mode acknowledges one cycle later.
module gpic_cpu_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Controller side
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic [1:0]  irq_level,
    output logic             irq_ack,
    output logic             irq_return,
    // Bench side
    input  wire logic        slow,
    input  wire logic        ret_cmd,
    output logic [15:0]      last_vec,
    output logic [1:0]       last_lvl,
    output int               n_ack
);
    logic seen_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_ack    <= 1'b0;
            irq_return <= 1'b0;
            seen_q     <= 1'b0;
            n_ack      <= 0;
        end else begin
            seen_q     <= irq_req && !irq_ack;
            irq_ack    <= irq_req && !irq_ack && (!slow || seen_q);
            irq_return <= ret_cmd;
            if (irq_ack && irq_req) begin
                last_vec <= irq_vector;
                last_lvl <= irq_level;
                n_ack    <= n_ack + 1;
            end
        end
    end
endmodule

// ==== test/gpic_ctrl_monitor.sv ====
// Purpose: Port assertions of the controller.
// Assumes: Synchronous active-low reset.
// Notes:   Tracks only the newest level in service.
module gpic_ctrl_monitor (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // APB
    input wire logic [9:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // CPU core
    input wire logic        irq_req,
    input wire logic [1:0]  irq_level,
    input wire logic        irq_ack,
    input wire logic        irq_return
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic       glb_q;
    logic       svc_q;
    logic [1:0] lvl_q;
    wire logic  rd_ok = pready && !pwrite && !pslverr;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            glb_q <= 1'b0;
            svc_q <= 1'b0;
            lvl_q <= 2'h0;
        end else begin
            if (pready && pwrite && !pslverr && paddr == 10'h2A0) begin
                glb_q <= pwdata[7];
            end
            if (irq_req && irq_ack) begin
                svc_q <= 1'b1;
                lvl_q <= irq_level;
            end else if (irq_return) begin
                svc_q <= 1'b0;
            end
        end
    end

    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
    property p_rdy_answer; psel && penable && !pready |=> pready; endproperty
    a_rdy_answer: assert property (p_rdy_answer) else $error("no pready");
    property p_prio_read; rd_ok && (paddr == 10'h2A4 || paddr == 10'h2E4) |-> prdata[31:6] == 26'h0; endproperty
    a_prio_read: assert property (p_prio_read) else $error("prio bits");
    property p_pri_read; rd_ok && paddr == 10'h2A0 |-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'h0; endproperty
    a_pri_read: assert property (p_pri_read) else $error("enable bits");
    property p_sec_read; rd_ok && (paddr == 10'h268 || paddr == 10'h2FC) |-> prdata[31:3] == 29'h0; endproperty
    a_sec_read: assert property (p_sec_read) else $error("secondary bits");
    property p_ack_drop; irq_req && irq_ack |=> !irq_req; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("req after ack");
    property p_preempt; svc_q && irq_req |-> irq_level > lvl_q; endproperty
    a_preempt: assert property (p_preempt) else $error("level not above service");
    property p_global; !glb_q && !$past(glb_q) |-> !irq_req; endproperty
    a_global: assert property (p_global) else $error("req while disabled");
endmodule

bind gpic_ctrl gpic_ctrl_monitor u_gpic_ctrl_monitor (
    .clock(clock),.rst_n(rst_n),.paddr(paddr),.psel(psel),.penable(penable),.pwrite(pwrite),
    .pwdata(pwdata),.prdata(prdata),.pready(pready),.pslverr(pslverr),.irq_req(irq_req),
    .irq_level(irq_level),.irq_ack(irq_ack),.irq_return(irq_return));

// ==== test/gpic_ctrl_tb.sv ====
// Purpose: Self-checking bench of the controller.
// Assumes: The CPU model acknowledges every request.
// Notes:   Register cases from a table, dispatch by hand.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module gpic_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [9:0] a;
        logic [7:0] w;
        logic [7:0] r;
        logic       e;
    } gpic_row_t;
    gpic_row_t   rows [8] = '{'{10'h2A0,8'hFF,8'h9F,1'h0}, '{10'h2A4,8'hFF,8'h3F,1'h0},
        '{10'h2E4,8'hFF,8'h3F,1'h0}, '{10'h268,8'hFF,8'h07,1'h0}, '{10'h2FC,8'hF8,8'h00,1'h0},
        '{10'h220,8'hFF,8'h00,1'h0}, '{10'h004,8'hFF,8'h00,1'h1}, '{10'h2A1,8'hFF,8'h00,1'h1}};
    int          ord [8] = '{7, 6, 5, 0, 1, 2, 3, 4};
    int          grp [8] = '{0, 0, 1, 1, 2, 3, 4, 5};
    logic [7:0]  lo = 8'h28;
    logic [7:0]  hi = 8'h30;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  paddr = 10'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, irq_req, irq_ack, irq_return;
    logic [7:0]  src_event = 8'h00;
    logic        serial_tx_event = 1'b0;
    logic        slow = 1'b0;
    logic        ret_cmd = 1'b0;
    logic [15:0] irq_vector, last_vec;
    logic [1:0]  irq_level, last_lvl;
    int          n_ack, n_seen = 0, n_tests = 0, n_mismatch = 0;

    gpic_ctrl u_gpic_ctrl (
        .clock(clock),.rst_n(rst_n),.paddr(paddr),.psel(psel),.penable(penable),.pwrite(pwrite),
        .pwdata(pwdata),.prdata(prdata),.pready(pready),.pslverr(pslverr),.src_event(src_event),
        .serial_tx_event(serial_tx_event),.irq_req(irq_req),.irq_vector(irq_vector),
        .irq_level(irq_level),.irq_ack(irq_ack),.irq_return(irq_return));
    gpic_cpu_model u_gpic_cpu_model (
        .clock(clock),.rst_n(rst_n),.irq_req(irq_req),.irq_vector(irq_vector),.irq_level(irq_level),
        .irq_ack(irq_ack),.irq_return(irq_return),.slow(slow),.ret_cmd(ret_cmd),
        .last_vec(last_vec),.last_lvl(last_lvl),.n_ack(n_ack));

    always #20 clock = ~clock;

    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 8 && pready !== 1'b1; i++) @(negedge clock);
        if (i == 8) begin
            n_mismatch++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [7:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", {24'h0, ex}, rd)
    endtask

    task automatic pulse(input logic [7:0] ev, input logic tx);
        @(posedge clock);
        src_event <= ev;
        serial_tx_event <= tx;
        @(posedge clock);
        src_event <= 8'h00;
        serial_tx_event <= 1'b0;
    endtask

    // Checks the next acknowledged vector and level.
    task automatic take(input int s, input logic [1:0] lv);
        int i;
        for (i = 0; i < 40 && n_ack == n_seen; i++) @(posedge clock);
        if (i == 40) begin
            n_mismatch++;
            test_done();
        end
        n_seen++;
        `CHK("vector", gpic_pkg::SRC_VECTOR[s*16 +: 16], last_vec)
        `CHK("level", lv, last_lvl)
        if (s == gpic_pkg::SRC_UART) apb(1'b1, 10'h260, 32'h0);
    endtask

    task automatic ret();
        @(posedge clock);
        ret_cmd <= 1'b1;
        @(posedge clock);
        ret_cmd <= 1'b0;
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clock);
            `CHK("irq_req", 1'b0, irq_req)
        end
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        `CHK("irq_vector", 16'h0003, irq_vector)
        foreach (rows[k]) begin
            rdchk(rows[k].a, 8'h00);
            apb(1'b1, rows[k].a, {24'h0, rows[k].w});
            rdchk(rows[k].a, rows[k].r);
            `CHK("pslverr", rows[k].e, er)
            apb(1'b1, rows[k].a, 32'h0);
        end
        apb(1'b1, 10'h2A0, 32'h9F);
        apb(1'b1, 10'h268, 32'h07);
        pulse(8'hFF, 1'b1);
        for (int s = 0; s < 8; s++) begin
            take(s, 2'h0);
            ret();
        end
        slow <= 1'b1;
        apb(1'b1, 10'h2A4, {24'h0, lo});
        apb(1'b1, 10'h2E4, {24'h0, hi});
        pulse(8'hFF, 1'b0);
        foreach (ord[i]) begin
            take(ord[i], {hi[grp[ord[i]]], lo[grp[ord[i]]]});
            ret();
        end
        slow <= 1'b0;
        apb(1'b1, 10'h2A4, 32'h02);
        apb(1'b1, 10'h2E4, 32'h08);
        pulse(8'h04, 1'b0);
        take(2, 2'h1);
        pulse(8'h09, 1'b0);
        quiet(6);
        pulse(8'h20, 1'b0);
        take(5, 2'h2);
        ret();
        quiet(4);
        ret();
        take(3, 2'h1);
        ret();
        take(0, 2'h0);
        ret();
        apb(1'b1, 10'h2A0, 32'h02);
        pulse(8'h04, 1'b0);
        quiet(6);
        rdchk(10'h220, 8'h20);
        apb(1'b1, 10'h220, 32'hFF);
        rdchk(10'h220, 8'h20);
        apb(1'b1, 10'h2A0, 32'h80);
        quiet(4);
        rdchk(10'h220, 8'h20);
        apb(1'b1, 10'h220, 32'hDF);
        rdchk(10'h220, 8'h00);
        apb(1'b1, 10'h2A4, 32'h3F);
        rst_n <= 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(10'h2A4, 8'h00);
        test_done();
    end
endmodule
